// ### logic/swdc_map.vh
`ifndef SWDC_MAP_VH
`define SWDC_MAP_VH
// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define SWDC_REG_ACK_FAIL      4'h0
`define SWDC_REG_PKT_STRENGTH  4'h1
`define SWDC_REG_SLEEP_MODE    4'h2
`define SWDC_REG_SLEEP_PERIOD  4'h3
`define SWDC_REG_WAKE_TIME     4'h4
`define SWDC_REG_PERIOD_COUNT  4'h5
`define SWDC_REG_SLEEP_OPTS    4'h6
`define SWDC_REG_HOST_WAKE     4'h7
`define SWDC_REG_POLL_RATE     4'h8
`define SWDC_REG_PARENT_TO     4'h9
`define SWDC_REG_COMMAND       4'hA
`define SWDC_REG_STATUS        4'hB
`define SWDC_REG_COORD_EN      4'hC
// ----------------------------------------------------------------
// Reset values, limits and defaults
// ----------------------------------------------------------------
`define SWDC_RST_SLEEP_PERIOD  16'h0020
`define SWDC_RST_WAKE_TIME     16'h1388
`define SWDC_RST_PERIOD_COUNT  16'h0001
`define SWDC_RST_PARENT_TO     4'h1
`define SWDC_SP_MIN            16'h0020
`define SWDC_SP_MAX            16'h0AF0
`define SWDC_PO_MAX            16'h03E8
`define SWDC_PO_DEFAULT        16'h000A
`define SWDC_ET_MAX            4'hE
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SWDC_OPT_FULL_WAKE     1
`define SWDC_OPT_EXTENDED      2
`define SWDC_CMD_SLEEP_NOW     0
`define SWDC_CMD_SCAN          1
`define SWDC_CMD_JOINED        2
// ----------------------------------------------------------------
// Sleep modes
// ----------------------------------------------------------------
`define SWDC_SM_ROUTER         3'h0
`define SWDC_SM_PIN            3'h1
`define SWDC_SM_CYCLIC         3'h4
`define SWDC_SM_CYCLIC_PIN     3'h5
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SWDC_CLK_HZ            125000000
`define SWDC_MS_NS             1000000
`define SWDC_CLK_NS            8
`define SWDC_MS_CYCLES         (`SWDC_MS_NS / `SWDC_CLK_NS)
`define SWDC_TICK10_MS         10
`endif

// ### logic/swdc_ms_tick.v
`timescale 1ns/100ps
module swdc_ms_tick #(
  parameter CYCLES = 125000
) (
  mclk,
  rst_n,
  ms_tick,
  tick10
);
  input  wire mclk;
  input  wire rst_n;
  output reg  ms_tick;
  output reg  tick10;

  reg [16:0] div_q;
  reg [3:0]  dec_q;

  // ----------------------------------------------------------------
  // Millisecond and 10 ms enables
  // ----------------------------------------------------------------
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      div_q   <= 17'h0_0000;
      dec_q   <= 4'h0;
      ms_tick <= 1'b0;
      tick10  <= 1'b0;
    end else begin
      ms_tick <= 1'b0;
      tick10  <= 1'b0;
      if (div_q == CYCLES[16:0] - 17'h0_0001) begin
        div_q   <= 17'h0_0000;
        ms_tick <= 1'b1;
        if (dec_q == 4'h9) begin
          dec_q  <= 4'h0;
          tick10 <= 1'b1;
        end else begin
          dec_q <= dec_q + 4'h1;
        end
      end else begin
        div_q <= div_q + 17'h0_0001;
      end
    end
  end
endmodule

// ### logic/swdc_ctrl.v
// Decided for this implementation: the address map and the plain strobed port.
`timescale 1ns/100ps
`include "swdc_map.vh"
module swdc_ctrl #(
  parameter MS_CYCLES = `SWDC_MS_CYCLES
) (
  mclk,
  rstn,
  reg_addr,
  reg_wdata,
  reg_wr,
  reg_rd,
  reg_rdata,
  ack_timeout,
  rx_valid,
  rx_strength,
  serial_rx,
  radio_rx,
  data_pending,
  pin_sleep_req,
  scan_energy,
  scan_valid,
  scan_last,
  frame_mode_select,
  char_data,
  char_valid,
  awake,
  sleep_status,
  host_tx_ok,
  poll_req,
  leave_rejoin,
  parent_timeout_code,
  parent_timeout_send,
  parent_timeout_sec,
  buffer_hold_10ms
);
  input  wire        mclk;
  input  wire        rstn;
  input  wire [3:0]  reg_addr;
  input  wire [15:0] reg_wdata;
  input  wire        reg_wr;
  input  wire        reg_rd;
  output reg  [15:0] reg_rdata;
  input  wire        ack_timeout;
  input  wire        rx_valid;
  input  wire [7:0]  rx_strength;
  input  wire        serial_rx;
  input  wire        radio_rx;
  input  wire        data_pending;
  input  wire        pin_sleep_req;
  input  wire [7:0]  scan_energy;
  input  wire        scan_valid;
  input  wire        scan_last;
  input  wire        frame_mode_select;
  output reg  [7:0]  char_data;
  output reg         char_valid;
  output reg         awake;
  output wire        sleep_status;
  output reg         host_tx_ok;
  output reg         poll_req;
  output reg         leave_rejoin;
  output reg  [3:0]  parent_timeout_code;
  output reg         parent_timeout_send;
  output reg  [19:0] parent_timeout_sec;
  output wire [15:0] buffer_hold_10ms;

  localparam ST_AWAKE = 2'h0;
  localparam ST_SLEEP = 2'h1;
  localparam ST_HWAKE = 2'h2;

  reg        rs1_q, rst_n;
  reg [15:0] ack_fail_count_q;
  reg [7:0]  last_packet_strength_q;
  reg [2:0]  sleep_mode_select_q;
  reg [15:0] sleep_period_q;
  reg [15:0] wake_time_q;
  reg [15:0] sleep_period_count_q;
  reg [7:0]  sleep_opts_q;
  reg [15:0] host_wake_delay_q;
  reg [15:0] poll_rate_q;
  reg        coord_en_q;
  reg [1:0]  state_q;
  reg [15:0] wake_cnt_q;
  reg [15:0] sleep_cnt_q;
  reg [15:0] period_num_q;
  reg [15:0] hwake_cnt_q;
  reg [15:0] poll_cnt_q;
  reg        sleep_now_q;
  reg [1:0]  char_ph_q;
  reg [7:0]  hex_q;
  reg        last_q;
  wire       ms_tick, tick10;
  wire       cyclic;
  wire       end_dev_new;
  wire       rx_any;
  wire [15:0] poll_lim;

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rs1_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rs1_q <= 1'b1;
      rst_n <= rs1_q;
    end
  end

  swdc_ms_tick #(.CYCLES(MS_CYCLES)) u_tick (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .ms_tick (ms_tick),
    .tick10  (tick10)
  );

  assign cyclic   = (sleep_mode_select_q == `SWDC_SM_CYCLIC) ||
                    (sleep_mode_select_q == `SWDC_SM_CYCLIC_PIN);
  assign rx_any   = serial_rx | radio_rx;
  assign end_dev_new = (reg_wdata[2:0] != `SWDC_SM_ROUTER);
  assign buffer_hold_10ms = sleep_period_q;
  assign sleep_status = awake;
  assign poll_lim = (poll_rate_q == 16'h0000) ? `SWDC_PO_DEFAULT : poll_rate_q;

  // ----------------------------------------------------------------
  // Register writes and diagnostics
  // ----------------------------------------------------------------
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ack_fail_count_q       <= 16'h0000;
      last_packet_strength_q <= 8'h00;
      sleep_mode_select_q    <= `SWDC_SM_ROUTER;
      sleep_period_q         <= `SWDC_RST_SLEEP_PERIOD;
      wake_time_q            <= `SWDC_RST_WAKE_TIME;
      sleep_period_count_q   <= `SWDC_RST_PERIOD_COUNT;
      sleep_opts_q           <= 8'h00;
      host_wake_delay_q      <= 16'h0000;
      poll_rate_q            <= 16'h0000;
      parent_timeout_code    <= `SWDC_RST_PARENT_TO;
      coord_en_q             <= 1'b0;
      leave_rejoin           <= 1'b0;
      parent_timeout_send    <= 1'b0;
      sleep_now_q            <= 1'b0;
    end else begin
      leave_rejoin        <= 1'b0;
      parent_timeout_send <= 1'b0;
      sleep_now_q         <= 1'b0;
      if (reg_wr && reg_addr == `SWDC_REG_ACK_FAIL)
        ack_fail_count_q <= reg_wdata;
      else if (ack_timeout && ack_fail_count_q != 16'hFFFF)
        ack_fail_count_q <= ack_fail_count_q + 16'h0001;
      if (rx_valid)
        last_packet_strength_q <= rx_strength;
      else if (reg_wr && reg_addr == `SWDC_REG_PKT_STRENGTH && reg_wdata == 16'h0000)
        last_packet_strength_q <= 8'h00;
      if (reg_wr) begin
        case (reg_addr)
          `SWDC_REG_SLEEP_MODE: begin
            case (reg_wdata[2:0])
              `SWDC_SM_ROUTER, `SWDC_SM_PIN, `SWDC_SM_CYCLIC, `SWDC_SM_CYCLIC_PIN: begin
                if (!(end_dev_new && coord_en_q) && reg_wdata[15:3] == 13'h0000) begin
                  sleep_mode_select_q <= reg_wdata[2:0];
                  if (end_dev_new != (sleep_mode_select_q != `SWDC_SM_ROUTER))
                    leave_rejoin <= 1'b1;
                end
              end
              default: ;
            endcase
          end
          `SWDC_REG_SLEEP_PERIOD:
            if (reg_wdata >= `SWDC_SP_MIN && reg_wdata <= `SWDC_SP_MAX)
              sleep_period_q <= reg_wdata;
          `SWDC_REG_WAKE_TIME:
            if (reg_wdata != 16'h0000)
              wake_time_q <= reg_wdata;
          `SWDC_REG_PERIOD_COUNT:
            if (reg_wdata != 16'h0000)
              sleep_period_count_q <= reg_wdata;
          `SWDC_REG_SLEEP_OPTS:
            sleep_opts_q <= reg_wdata[7:0] & 8'h06;
          `SWDC_REG_HOST_WAKE:
            host_wake_delay_q <= reg_wdata;
          `SWDC_REG_POLL_RATE:
            if (reg_wdata <= `SWDC_PO_MAX)
              poll_rate_q <= reg_wdata;
          `SWDC_REG_PARENT_TO:
            if (reg_wdata <= {12'h000, `SWDC_ET_MAX})
              parent_timeout_code <= reg_wdata[3:0];
          `SWDC_REG_COORD_EN:
            coord_en_q <= reg_wdata[0];
          `SWDC_REG_COMMAND: begin
            sleep_now_q <= reg_wdata[`SWDC_CMD_SLEEP_NOW];
            parent_timeout_send <= reg_wdata[`SWDC_CMD_JOINED] &&
                                   sleep_mode_select_q != `SWDC_SM_ROUTER;
          end
          default: ;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Parent timeout in seconds
  // ----------------------------------------------------------------
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n)
      parent_timeout_sec <= 20'h0_0000;
    else if (parent_timeout_code == 4'h0)
      parent_timeout_sec <= 20'h0_000A;
    else
      parent_timeout_sec <= 20'h0_003C << parent_timeout_code;
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n)
      reg_rdata <= 16'h0000;
    else if (reg_rd) begin
      case (reg_addr)
        `SWDC_REG_ACK_FAIL:     reg_rdata <= ack_fail_count_q;
        `SWDC_REG_PKT_STRENGTH: reg_rdata <= {8'h00, last_packet_strength_q};
        `SWDC_REG_SLEEP_MODE:   reg_rdata <= {13'h0000, sleep_mode_select_q};
        `SWDC_REG_SLEEP_PERIOD: reg_rdata <= sleep_period_q;
        `SWDC_REG_WAKE_TIME:    reg_rdata <= wake_time_q;
        `SWDC_REG_PERIOD_COUNT: reg_rdata <= sleep_period_count_q;
        `SWDC_REG_SLEEP_OPTS:   reg_rdata <= {8'h00, sleep_opts_q};
        `SWDC_REG_HOST_WAKE:    reg_rdata <= host_wake_delay_q;
        `SWDC_REG_POLL_RATE:    reg_rdata <= poll_rate_q;
        `SWDC_REG_PARENT_TO:    reg_rdata <= {12'h000, parent_timeout_code};
        `SWDC_REG_STATUS:       reg_rdata <= {14'h0000, state_q};
        `SWDC_REG_COORD_EN:     reg_rdata <= {15'h0000, coord_en_q};
        default:                reg_rdata <= 16'h0000;
      endcase
    end else
      reg_rdata <= 16'h0000;
  end

  // ----------------------------------------------------------------
  // Sleep sequencer
  // ----------------------------------------------------------------
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_q      <= ST_AWAKE;
      awake        <= 1'b1;
      host_tx_ok   <= 1'b1;
      wake_cnt_q   <= 16'h0000;
      sleep_cnt_q  <= 16'h0000;
      period_num_q <= 16'h0000;
      hwake_cnt_q  <= 16'h0000;
    end else begin
      case (state_q)
        ST_AWAKE: begin
          awake <= 1'b1;
          if (rx_any)
            wake_cnt_q <= 16'h0000;
          else if (ms_tick && wake_cnt_q < wake_time_q)
            wake_cnt_q <= wake_cnt_q + 16'h0001;
          if (sleep_mode_select_q == `SWDC_SM_PIN && pin_sleep_req) begin
            state_q <= ST_SLEEP;
            awake   <= 1'b0;
          end else if (cyclic && (sleep_now_q ||
                       (wake_cnt_q >= wake_time_q && !rx_any) ||
                       (!sleep_opts_q[`SWDC_OPT_FULL_WAKE] && !data_pending &&
                        wake_cnt_q != 16'h0000 && !rx_any && 1'b0))) begin
            state_q      <= ST_SLEEP;
            awake        <= 1'b0;
            sleep_cnt_q  <= 16'h0000;
            period_num_q <= 16'h0000;
            host_tx_ok   <= 1'b0;
          end
        end
        ST_SLEEP: begin
          if (sleep_mode_select_q == `SWDC_SM_PIN) begin
            if (!pin_sleep_req)
              state_q <= ST_HWAKE;
          end else if (sleep_mode_select_q == `SWDC_SM_CYCLIC_PIN && pin_sleep_req) begin
            state_q <= ST_HWAKE;
          end else if (!cyclic) begin
            state_q <= ST_HWAKE;
          end else if (tick10) begin
            if (sleep_cnt_q + 16'h0001 >= sleep_period_q) begin
              sleep_cnt_q  <= 16'h0000;
              period_num_q <= period_num_q + 16'h0001;
              if (period_num_q + 16'h0001 >= sleep_period_count_q ||
                  (data_pending && !sleep_opts_q[`SWDC_OPT_EXTENDED]))
                state_q <= ST_HWAKE;
            end else
              sleep_cnt_q <= sleep_cnt_q + 16'h0001;
          end
          if (state_q != ST_SLEEP || sleep_mode_select_q == `SWDC_SM_ROUTER)
            awake <= 1'b1;
          hwake_cnt_q <= 16'h0000;
          wake_cnt_q  <= 16'h0000;
        end
        ST_HWAKE: begin
          awake <= 1'b1;
          if (serial_rx || hwake_cnt_q >= host_wake_delay_q) begin
            host_tx_ok <= 1'b1;
            state_q    <= ST_AWAKE;
          end else if (ms_tick)
            hwake_cnt_q <= hwake_cnt_q + 16'h0001;
        end
        default: state_q <= ST_AWAKE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Poll timer
  // ----------------------------------------------------------------
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      poll_cnt_q <= 16'h0000;
      poll_req   <= 1'b0;
    end else begin
      poll_req <= 1'b0;
      if (!awake || sleep_mode_select_q == `SWDC_SM_ROUTER)
        poll_cnt_q <= 16'h0000;
      else if (tick10) begin
        if (poll_cnt_q + 16'h0001 >= poll_lim) begin
          poll_cnt_q <= 16'h0000;
          poll_req   <= 1'b1;
        end else
          poll_cnt_q <= poll_cnt_q + 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // Energy scan text output
  // ----------------------------------------------------------------
  function [7:0] hex_chr;
    input [3:0] n;
    begin
      hex_chr = (n < 4'hA) ? {4'h3, n} : (8'h37 + {4'h0, n});
    end
  endfunction

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      char_ph_q  <= 2'h0;
      hex_q      <= 8'h00;
      last_q     <= 1'b0;
      char_data  <= 8'h00;
      char_valid <= 1'b0;
    end else begin
      char_valid <= 1'b0;
      case (char_ph_q)
        2'h0: if (scan_valid && !frame_mode_select) begin
          hex_q      <= scan_energy;
          last_q     <= scan_last;
          char_data  <= hex_chr(scan_energy[7:4]);
          char_valid <= 1'b1;
          char_ph_q  <= 2'h1;
        end
        2'h1: begin
          char_data  <= hex_chr(hex_q[3:0]);
          char_valid <= 1'b1;
          char_ph_q  <= 2'h2;
        end
        2'h2: begin
          char_data  <= 8'h2C;
          char_valid <= 1'b1;
          char_ph_q  <= last_q ? 2'h3 : 2'h0;
        end
        2'h3: begin
          char_data  <= 8'h0D;
          char_valid <= 1'b1;
          char_ph_q  <= 2'h0;
        end
        default: char_ph_q <= 2'h0;
      endcase
    end
  end
endmodule

// ### tb/swdc_ctrl_monitor.sv
`timescale 1ns/100ps
module swdc_ctrl_monitor (
  input wire        mclk,
  input wire        rstn,
  input wire        serial_rx,
  input wire        scan_valid,
  input wire        scan_last,
  input wire        frame_mode_select,
  input wire [7:0]  char_data,
  input wire        char_valid,
  input wire        awake,
  input wire        sleep_status,
  input wire        host_tx_ok,
  input wire        poll_req,
  input wire        leave_rejoin,
  input wire [3:0]  parent_timeout_code,
  input wire        parent_timeout_send,
  input wire [19:0] parent_timeout_sec,
  input wire [15:0] buffer_hold_10ms
);
  // ----------------------------------------------------------------
  // Settling counter after reset release
  // ----------------------------------------------------------------
  logic [2:0] up_q;
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) up_q <= 3'h0;
    else if (up_q != 3'h7) up_q <= up_q + 3'h1;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  sequence s_val_chars;
    char_valid [*2] ##1 (char_valid && char_data == 8'h2C);
  endsequence
  AST_STATUS_LINE: assert property (sleep_status == awake)
    else $error("sleep status differs from awake");
  AST_SCAN_CHARS: assert property (scan_valid && !frame_mode_select |=> s_val_chars)
    else $error("scan value not sent as two digits and comma");
  AST_SCAN_CR: assert property (scan_valid && scan_last && !frame_mode_select |=>
    s_val_chars ##1 (char_valid && char_data == 8'h0D))
    else $error("scan list not closed by carriage return");
  AST_HOLD_RANGE: assert property (up_q == 3'h7 |->
    buffer_hold_10ms >= 16'h0020 && buffer_hold_10ms <= 16'h0AF0)
    else $error("buffer hold outside sleep period range");
  AST_TO_SEC: assert property (up_q == 3'h7 && $stable(parent_timeout_code) |->
    parent_timeout_sec == ((parent_timeout_code == 4'h0) ? 20'h0_000A :
    (20'h0_003C << parent_timeout_code)))
    else $error("parent timeout seconds wrong for code");
  AST_TO_CODE: assert property (parent_timeout_code <= 4'hE)
    else $error("parent timeout code above fourteen");
  AST_SEND_PULSE: assert property (parent_timeout_send |=> !parent_timeout_send)
    else $error("timeout send longer than one cycle");
  AST_REJOIN_PULSE: assert property (leave_rejoin |=> !leave_rejoin)
    else $error("leave rejoin longer than one cycle");
  AST_POLL_AWAKE: assert property (poll_req |-> awake)
    else $error("poll request while asleep");
  AST_HOST_RELEASE: assert property (serial_rx && awake |-> ##[1:2] host_tx_ok)
    else $error("host delay not stopped by serial input");
endmodule
bind swdc_ctrl swdc_ctrl_monitor i_swdc_ctrl_monitor (.mclk, .rstn, .serial_rx,
  .scan_valid, .scan_last, .frame_mode_select, .char_data, .char_valid, .awake,
  .sleep_status, .host_tx_ok, .poll_req, .leave_rejoin, .parent_timeout_code,
  .parent_timeout_send, .parent_timeout_sec, .buffer_hold_10ms);

// ### tb/swdc_host_model.sv
`timescale 1ns/100ps
module swdc_host_model (
  input  wire         mclk,
  output logic [3:0]  reg_addr,
  output logic [15:0] reg_wdata,
  output logic        reg_wr,
  output logic        reg_rd,
  input  wire  [15:0] reg_rdata,
  output logic        serial_rx
);
  initial begin
    reg_addr  = 4'h0;
    reg_wdata = 16'h0000;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    serial_rx = 1'b0;
  end
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr    <= 1'b0;
    reg_wdata <= ~d;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd   <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  // Coordinator cleared before any nonzero mode
  task automatic end_device(input logic [15:0] m);
    wr(4'hC, 16'h0000);
    wr(4'h2, m);
  endtask
  task automatic ser;
    @(posedge mclk);
    serial_rx <= 1'b1;
    @(posedge mclk);
    serial_rx <= 1'b0;
  endtask
endmodule

// ### tb/testbench.sv
`timescale 1ns/100ps
module testbench;
  logic mclk = 1'b0, rstn = 1'b0, ack_timeout = 1'b0, rx_valid = 1'b0;
  logic scan_valid = 1'b0, scan_last = 1'b0, serial_rx;
  logic radio_rx = 1'b0, frame_mode_select = 1'b0, sent;
  logic [7:0] rx_strength = 8'h00, scan_energy = 8'h00, char_data;
  logic [3:0] reg_addr, parent_timeout_code;
  logic [15:0] reg_wdata, reg_rdata, d;
  logic reg_wr, reg_rd, char_valid, awake, sleep_status, host_tx_ok, hit;
  logic [19:0] parent_timeout_sec;
  int miscompares = 0, tests_run = 0, n, k;
  always #4 mclk = ~mclk;
  swdc_host_model i_swdc_host_model (.mclk, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .serial_rx);
  swdc_ctrl #(.MS_CYCLES(10)) i_swdc_ctrl (.mclk, .rstn, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .ack_timeout, .rx_valid, .rx_strength, .serial_rx,
    .radio_rx, .data_pending(1'b0), .pin_sleep_req(1'b0), .scan_energy,
    .scan_valid, .scan_last, .frame_mode_select, .char_data, .char_valid,
    .awake, .sleep_status, .host_tx_ok, .poll_req(), .leave_rejoin(hit),
    .parent_timeout_code, .parent_timeout_send(sent), .parent_timeout_sec,
    .buffer_hold_10ms());
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rdchk(input logic [3:0] a, input logic [15:0] e);
    i_swdc_host_model.rd(a, d);
    chk({4'h0, d}, {4'h0, e});
  endtask
  task automatic wait_aw(input logic v, input int lim, output int c);
    c = 0;
    while (awake !== v) begin
      @(posedge mclk);
      #1;
      c++;
      if (c > lim) begin
        miscompares++;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, awake, v);
        wrap_up;
      end
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    i_swdc_host_model.wr(a, v);
  endtask
  task automatic wrap_up;
    $display("tests_run=%0d miscompares=%0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_ack;
    rdchk(4'h0, 16'h0000);
    for (k = 0; k < 6; k++) begin
      @(posedge mclk) ack_timeout <= (k == 1 || k == 3 || k == 4);
    end
    rdchk(4'h0, 16'h0003);
    wr(4'h0, 16'hFFFE);
    for (k = 0; k < 4; k++) @(posedge mclk) ack_timeout <= ~k[0];
    rdchk(4'h0, 16'hFFFF);
    $display("test ack done");
  endtask
  task automatic t_strength;
    @(posedge mclk) {rx_valid, rx_strength} <= 9'h1_50;
    @(posedge mclk) {rx_valid, rx_strength} <= 9'h0_AF;
    rdchk(4'h1, 16'h0050);
    wr(4'h1, 16'h0000);
    rdchk(4'h1, 16'h0000);
    $display("test strength done");
  endtask
  task automatic t_scan;
    logic [7:0] ex [4] = '{8'h34, 8'h39, 8'h2C, 8'h0D};
    @(posedge mclk) {scan_valid, scan_last, scan_energy} <= 10'h3_49;
    @(posedge mclk) {scan_valid, scan_last, scan_energy} <= 10'h0_B6;
    k = 0;
    repeat (6) begin
      #1;
      if (char_valid === 1'b1 && k < 4) chk(char_data, ex[k]);
      if (char_valid === 1'b1) k++;
      @(posedge mclk);
    end
    chk(k, 4);
    @(posedge mclk) {frame_mode_select, scan_valid} <= 2'b11;
    @(posedge mclk) {frame_mode_select, scan_valid} <= 2'b10;
    k = 0;
    repeat (5) begin
      @(posedge mclk);
      #1;
      if (char_valid !== 1'b0) k++;
    end
    @(posedge mclk) frame_mode_select <= 1'b0;
    chk(k, 0);
    $display("test scan done");
  endtask
  task automatic t_mode;
    for (n = 0; n < 8; n++) begin
      wr(4'h2, 16'h0000);
      wr(4'h2, n);
      rdchk(4'h2, (n == 1 || n == 4 || n == 5) ? n : 0);
    end
    wr(4'h2, 16'h0000);
    wr(4'hC, 16'h0001);
    wr(4'h2, 16'h0004);
    rdchk(4'h2, 16'h0000);
    i_swdc_host_model.end_device(16'h0004);
    k = 0;
    repeat (4) begin
      #1;
      if (hit === 1'b1) k++;
      @(posedge mclk);
    end
    chk(k, 1);
    $display("test mode done");
  endtask
  task automatic t_range;
    logic [3:0] a [5] = '{4'h3, 4'h3, 4'h8, 4'h4, 4'h5};
    logic [15:0] v [5] = '{16'h0AF0, 16'h0AF1, 16'h03E9, 16'h0000, 16'h0000};
    logic [15:0] e [5] = '{16'h0AF0, 16'h0AF0, 16'h0000, 16'h1388, 16'h0001};
    wr(4'h8, 16'h0000);
    wr(4'h3, 16'h001F);
    rdchk(4'h3, 16'h0020);
    for (n = 0; n < 5; n++) begin
      wr(a[n], v[n]);
      rdchk(a[n], e[n]);
    end
    wr(4'h6, 16'h00FF);
    rdchk(4'h6, 16'h0006);
    wr(4'h9, 16'h000F);
    rdchk(4'h9, 16'h0001);
    wr(4'h9, 16'h000E);
    repeat (2) @(posedge mclk);
    chk(parent_timeout_sec, 20'hF_0000);
    wr(4'h9, 16'h0000);
    repeat (2) @(posedge mclk);
    chk(parent_timeout_sec, 20'h0_000A);
    wr(4'h9, 16'h0001);
    wr(4'h6, 16'h0000);
    wr(4'h3, 16'h0020);
    $display("test range done");
  endtask
  task automatic t_sleep;
    wr(4'hA, 16'h0004);
    #1;
    chk(parent_timeout_code, 4'h1);
    chk(sent, 1'b1);
    wr(4'h4, 16'h0008);
    wr(4'h7, 16'h0005);
    wr(4'hA, 16'h0001);
    wait_aw(1'b0, 8, n);
    chk(sleep_status, 1'b0);
    wait_aw(1'b1, 4000, n);
    chk(n > 3000 && n < 3300, 1'b1);
    repeat (20) @(posedge mclk);
    #1;
    chk(host_tx_ok, 1'b0);
    i_swdc_host_model.ser;
    repeat (2) @(posedge mclk);
    #1;
    chk(host_tx_ok, 1'b1);
    repeat (40) @(posedge mclk);
    radio_rx <= 1'b1;
    @(posedge mclk) radio_rx <= 1'b0;
    wait_aw(1'b0, 200, n);
    chk(n > 70 && n < 95, 1'b1);
    chk(sleep_status, 1'b0);
    $display("test sleep done");
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (3) @(posedge mclk);
    rstn <= 1'b1;
    repeat (4) @(posedge mclk);
    t_ack;
    t_strength;
    t_scan;
    t_mode;
    t_range;
    t_sleep;
    wrap_up;
  end
  initial begin
    repeat (20000) @(posedge mclk);
    miscompares++;
    wrap_up;
  end
endmodule
